// *** ltw_recognizer.sv ***
// Logic-trigger word recognizer: functions A/B, nesting, filter, display sequencing
//
// Behaviour
// R1: Terms: high, low, or don't care
// R2: Terms may match rising or falling edges
// R3: Two columns, each AND of four terms
// R4: Function is OR of both columns
// R5: All-don't-care column counts as false
// R6: Two stored functions; selected one drives output
// R7: Programming selected function spares the other
// R8: Nested: arm on A, fire on B
// R9: After nested fire, wait for A again
// R10: Monitor shows trigger, or external clock
// R11: All displays off forces monitor on
// R12: Filter suppresses short true intervals
// R13: Filter bypassed for edge-sensitive functions
// R14: Filter separate per function; optional on B
// R15: Filter bypassed in clock-qualify or off
// R16: Chopped mode switches channels near 1 MHz
// R17: Alternate mode advances after each sweep
// R18: Undisplayed channel still feeds trigger unless grounded
// R19: Grounded channel feeds ground, stays displayed
// R20: Logic family selects per-channel threshold range
// R21: Clock-qualify fires only on chosen edge
// R22: Reset input clears arming, inhibits B
// R23: Reject edge terms with clock-qualify, both ways
// R24: Nested output is a pulse in normal mode
// R25: Filter counts system clock cycles
`timescale 1ns/10ps
module ltw_recognizer (
   input wire logic clk, // System clock, 100 MHz
   input wire logic reset, // Synchronous reset, high
   input wire logic [ltw_pkg::NCH-1:0] comparator_in, // Channel comparators above threshold
   input wire logic [ltw_pkg::NCH-1:0] channel_ground, // Channel grounded
   input wire logic [ltw_pkg::NCH-1:0] display_enable, // Channel display on
   input wire logic [ltw_pkg::NCH-1:0] logic_family_select, // 1 = TTL range, 0 = ECL
   input wire ltw_pkg::ltw_prog_s prog, // Function programming request
   input wire ltw_pkg::ltw_mode_e mode, // A, B or A then B
   input wire logic external_clock_qualify_req, // Requested clock-qualify state
   input wire logic ext_clock_rising, // Qualify on rising edge when high
   input wire logic ext_clock_in, // External clock, synchronous
   input wire logic reset_in, // Trigger inhibit input
   input wire logic [ltw_pkg::FILT_W-1:0] filter_cycles, // Filter length, 0 = off
   input wire logic filter_b_disable, // No filter on B in nested mode
   input wire logic gate_mode, // 1 = gate output in nested mode
   input wire logic monitor_req, // Operator request for monitor trace
   input wire logic alternate_chopped_select, // 1 = alternate, 0 = chopped
   input wire logic sweep_done, // One-cycle pulse at sweep end
   output logic trigger_out, // Trigger to time base
   output logic trigger_monitor_trace, // Monitor trace signal
   output logic trigger_monitor_on, // Monitor trace displayed
   output logic external_clock_qualify, // Clock-qualify in effect
   output logic prog_rejected, // Last edit or clock-qualify request rejected
   output logic armed, // Nested mode armed by A
   output logic [1:0] display_channel, // Channel being displayed
   output logic [ltw_pkg::NCH-1:0] amp_in, // Level fed to each amplifier
   output logic [ltw_pkg::NCH-1:0] ttl_range // Threshold range select per channel
);
   typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_FIRED} ltw_nest_e;

   ltw_pkg::ltw_func_s func_a_q, func_b_q;
   ltw_pkg::ltw_func_s func_a_d, func_b_d;
   logic [ltw_pkg::NCH-1:0] lvl_q, lvl_prev_q;
   logic ext_prev_q, xq_q, rej_q, trig_q, mon_q, mon_on_q;
   logic [ltw_pkg::CHOP_W-1:0] chop_q;
   logic [1:0] disp_q;
   logic [ltw_pkg::NCH-1:0] lvl;
   ltw_nest_e nest_q, nest_d;

   // Term match against current and previous level
   function automatic logic term_match(input ltw_pkg::ltw_term_e t, input logic cur,
                                       input logic prv);
      unique case (t)
         ltw_pkg::LTW_DONT_CARE: term_match = 1'b1; // see R1
         ltw_pkg::LTW_HIGH: term_match = cur; // see R1
         ltw_pkg::LTW_LOW: term_match = !cur; // see R1
         ltw_pkg::LTW_RISE: term_match = cur && !prv; // see R2
         ltw_pkg::LTW_FALL: term_match = !cur && prv; // see R2
         default: term_match = 1'b0;
      endcase
   endfunction : term_match

   function automatic logic func_eval(input ltw_pkg::ltw_func_s f,
                                      input logic [ltw_pkg::NCH-1:0] cur,
                                      input logic [ltw_pkg::NCH-1:0] prv);
      logic res, col_and, col_act;
      res = 1'b0;
      for (int c = 0; c < ltw_pkg::NCOL; c++) begin
         col_and = 1'b1;
         col_act = 1'b0;
         for (int i = 0; i < ltw_pkg::NCH; i++) begin
            col_and &= term_match(f.col[c].term[i], cur[i], prv[i]); // see R3
            col_act |= (f.col[c].term[i] != ltw_pkg::LTW_DONT_CARE);
         end
         res |= col_and && col_act; // see R4 R5
      end
      func_eval = res;
   endfunction : func_eval

   function automatic logic has_edge(input ltw_pkg::ltw_func_s f);
      logic e;
      e = 1'b0;
      for (int c = 0; c < ltw_pkg::NCOL; c++) begin
         for (int i = 0; i < ltw_pkg::NCH; i++) begin
            e |= (f.col[c].term[i] == ltw_pkg::LTW_RISE) ||
                 (f.col[c].term[i] == ltw_pkg::LTW_FALL);
         end
      end
      has_edge = e;
   endfunction : has_edge

   // Grounded channels feed ground; undisplayed ones still feed the trigger
   assign lvl = comparator_in & ~channel_ground; // see R18 R19
   assign amp_in = lvl;
   assign ttl_range = logic_family_select; // see R20

   // Programming of the selected function only
   logic edit_is_edge, edit_ok, edge_any;
   ltw_pkg::ltw_func_s edited;
   assign edit_is_edge = (prog.term == ltw_pkg::LTW_RISE) || (prog.term == ltw_pkg::LTW_FALL);
   assign edit_ok = prog.clear || !(edit_is_edge && xq_q); // see R23
   assign edge_any = has_edge(func_a_q) || has_edge(func_b_q);

   always_comb begin
      edited = prog.sel_b ? func_b_q : func_a_q;
      if (prog.clear) begin
         edited = '0;
      end else begin
         edited.col[prog.col].term[prog.chan] = prog.term;
      end
   end

   assign func_a_d = (prog.write && edit_ok && !prog.sel_b) ? edited : func_a_q; // see R7
   assign func_b_d = (prog.write && edit_ok && prog.sel_b) ? edited : func_b_q; // see R7

   // Raw evaluations and filters
   logic raw_a, raw_b, filt_a, filt_b, byp_a, byp_b, filt_off;
   assign raw_a = func_eval(func_a_q, lvl_q, lvl_prev_q) && !reset_in;
   assign raw_b = func_eval(func_b_q, lvl_q, lvl_prev_q) && !reset_in;
   assign filt_off = (filter_cycles == ltw_pkg::FILT_OFF) || xq_q; // see R15
   assign byp_a = filt_off || has_edge(func_a_q); // see R13
   assign byp_b = filt_off || has_edge(func_b_q) ||
                  (filter_b_disable && mode == ltw_pkg::LTW_MODE_A_THEN_B); // see R14

   ltw_filter u_filt_a (
      .clk(clk),
      .reset(reset),
      .level_in(raw_a),
      .bypass(byp_a),
      .duration(filter_cycles),
      .level_out(filt_a)
   );

   ltw_filter u_filt_b (
      .clk(clk),
      .reset(reset),
      .level_in(raw_b),
      .bypass(byp_b),
      .duration(filter_cycles),
      .level_out(filt_b)
   );

   // External clock qualification
   logic ext_edge;
   assign ext_edge = ext_clock_rising ? (ext_clock_in && !ext_prev_q)
                                      : (!ext_clock_in && ext_prev_q); // see R21

   // Nested arming
   always_comb begin
      nest_d = nest_q;
      unique case (nest_q)
         ST_IDLE: begin
            if (filt_a && (!xq_q || ext_edge)) begin
               nest_d = ST_ARMED; // see R8
            end
         end
         ST_ARMED: begin
            if (reset_in) begin
               nest_d = ST_IDLE; // see R22
            end else if (filt_b && (!xq_q || ext_edge)) begin
               nest_d = ST_FIRED; // see R8
            end
         end
         ST_FIRED: begin
            if (!(gate_mode && filt_b)) begin
               nest_d = ST_IDLE; // see R9 R24
            end
         end
      endcase
      if (mode != ltw_pkg::LTW_MODE_A_THEN_B) begin
         nest_d = ST_IDLE;
      end
   end

   logic sel_val, trig_d, mon_on_d;
   assign sel_val = (mode == ltw_pkg::LTW_MODE_B) ? filt_b : filt_a; // see R6
   always_comb begin
      if (mode == ltw_pkg::LTW_MODE_A_THEN_B) begin
         trig_d = (nest_d == ST_FIRED) && (gate_mode || nest_q != ST_FIRED); // see R24
      end else if (xq_q) begin
         trig_d = sel_val && ext_edge; // see R21
      end else begin
         trig_d = sel_val;
      end
   end
   assign mon_on_d = monitor_req || (display_enable == '0); // see R11

   // Display channel sequencing
   function automatic logic [1:0] next_chan(input logic [1:0] cur,
                                            input logic [ltw_pkg::NCH-1:0] en);
      logic [1:0] n, pick;
      logic found;
      pick = cur;
      found = 1'b0;
      for (int k = 1; k <= ltw_pkg::NCH; k++) begin
         n = 2'(int'(cur) + k);
         if (!found && en[n]) begin
            pick = n;
            found = 1'b1;
         end
      end
      next_chan = pick;
   endfunction : next_chan

   logic chop_wrap, step;
   assign chop_wrap = (chop_q == ltw_pkg::CHOP_W'(ltw_pkg::CHOP_CYC - 1));
   assign step = alternate_chopped_select ? sweep_done : chop_wrap; // see R16 R17

   always_ff @(posedge clk) begin
      if (reset) begin
         func_a_q <= '0;
         func_b_q <= '0;
         lvl_q <= '0;
         lvl_prev_q <= '0;
         ext_prev_q <= 1'b0;
         xq_q <= 1'b0;
         rej_q <= 1'b0;
         nest_q <= ST_IDLE;
         trig_q <= 1'b0;
         mon_q <= 1'b0;
         mon_on_q <= 1'b1;
         chop_q <= '0;
         disp_q <= ltw_pkg::CH_FIRST;
      end else begin
         func_a_q <= func_a_d;
         func_b_q <= func_b_d;
         lvl_q <= lvl;
         lvl_prev_q <= lvl_q;
         ext_prev_q <= ext_clock_in;
         if (external_clock_qualify_req && !xq_q && edge_any) begin
            rej_q <= 1'b1; // see R23
         end else if (prog.write && !edit_ok) begin
            rej_q <= 1'b1; // see R23
         end else if (prog.write || external_clock_qualify_req != xq_q) begin
            rej_q <= 1'b0;
         end
         xq_q <= external_clock_qualify_req && (xq_q || !edge_any); // see R23
         nest_q <= nest_d;
         trig_q <= trig_d;
         mon_q <= xq_q ? ext_clock_in : trig_d; // see R10
         mon_on_q <= mon_on_d; // see R11
         chop_q <= chop_wrap ? '0 : chop_q + 1'b1;
         if (step) begin
            disp_q <= next_chan(disp_q, display_enable);
         end
      end
   end

   assign trigger_out = trig_q;
   assign trigger_monitor_trace = mon_q;
   assign trigger_monitor_on = mon_on_q;
   assign external_clock_qualify = xq_q;
   assign prog_rejected = rej_q;
   assign armed = (nest_q == ST_ARMED);
   assign display_channel = disp_q;

   nest_pulse_a: assert property (@(posedge clk) disable iff (reset) // see R24
      (mode == ltw_pkg::LTW_MODE_A_THEN_B && !gate_mode && trigger_out) |=> !trigger_out)
      else $error("nested trigger longer than a pulse");
   nest_arm_a: assert property (@(posedge clk) disable iff (reset) // see R8
      (mode == ltw_pkg::LTW_MODE_A_THEN_B && $rose(trigger_out)) |-> $past(armed))
      else $error("nested trigger without arming");
   nest_disarm_a: assert property (@(posedge clk) disable iff (reset) // see R9
      (mode == ltw_pkg::LTW_MODE_A_THEN_B && $rose(trigger_out)) |-> !armed)
      else $error("still armed after nested trigger");
   inhibit_arm_a: assert property (@(posedge clk) disable iff (reset) // see R22
      (armed && reset_in && mode == ltw_pkg::LTW_MODE_A_THEN_B) |=> !armed && !trigger_out)
      else $error("reset input did not disarm");
   monitor_force_a: assert property (@(posedge clk) disable iff (reset) // see R11
      (display_enable == '0) |=> trigger_monitor_on)
      else $error("monitor not forced on");
   monitor_src_a: assert property (@(posedge clk) disable iff (reset) // see R10
      !$past(xq_q) |-> (trigger_monitor_trace == trigger_out))
      else $error("monitor does not follow trigger");
   excl_qualify_a: assert property (@(posedge clk) disable iff (reset) // see R23
      external_clock_qualify |-> !(has_edge(func_a_q) || has_edge(func_b_q)))
      else $error("edge term with clock qualify");
   qual_edge_a: assert property (@(posedge clk) disable iff (reset) // see R21
      (xq_q && mode != ltw_pkg::LTW_MODE_A_THEN_B && !ext_edge) |=> !trigger_out)
      else $error("qualified trigger off clock edge");
   unsel_keep_a: assert property (@(posedge clk) disable iff (reset) // see R7
      (prog.write && !prog.sel_b) |=> $stable(func_b_q))
      else $error("unselected function changed");
   chop_step_a: assert property (@(posedge clk) disable iff (reset) // see R16
      (!alternate_chopped_select && chop_q != 8'h00) |=> $stable(disp_q) || chop_q == 8'h00)
      else $error("chopped channel switched early");

   nest_fire_c: cover property (@(posedge clk) disable iff (reset)
      mode == ltw_pkg::LTW_MODE_A_THEN_B && $rose(trigger_out));
   qual_fire_c: cover property (@(posedge clk) disable iff (reset)
      xq_q && $rose(trigger_out));
   reject_c: cover property (@(posedge clk) disable iff (reset) $rose(prog_rejected));
   alt_step_c: cover property (@(posedge clk) disable iff (reset)
      alternate_chopped_select && sweep_done);
endmodule : ltw_recognizer

// *** ltw_pkg.sv ***
// Package for the logic-trigger word recognizer: types and constants
package ltw_pkg;
   localparam int NCH = 4;
   localparam int NCOL = 2;
   localparam int FILT_W = 16;
   localparam int CHOP_HZ = 1000000;
   localparam int CLK_HZ = 100000000;
   localparam int CHOP_CYC = CLK_HZ / CHOP_HZ;
   localparam int CHOP_W = 8;
   localparam logic [FILT_W-1:0] FILT_OFF = 16'h0000;
   localparam logic [1:0] CH_FIRST = 2'h0;
   localparam logic [1:0] CH_LAST = 2'h3;

   // Term encoding per channel
   typedef enum logic [2:0] {
      LTW_DONT_CARE,
      LTW_HIGH,
      LTW_LOW,
      LTW_RISE,
      LTW_FALL
   } ltw_term_e;

   typedef struct packed {
      ltw_term_e [NCH-1:0] term;
   } ltw_col_s;

   typedef struct packed {
      ltw_col_s [NCOL-1:0] col;
   } ltw_func_s;

   typedef enum logic [1:0] {
      LTW_MODE_A,
      LTW_MODE_B,
      LTW_MODE_A_THEN_B
   } ltw_mode_e;

   // Programming request from the front panel
   typedef struct packed {
      logic write;
      logic clear;
      logic sel_b;
      logic [0:0] col;
      logic [1:0] chan;
      ltw_term_e term;
   } ltw_prog_s;
endpackage : ltw_pkg

// *** ltw_filter.sv ***
// Minimum-duration trigger filter for one trigger function
`timescale 1ns/10ps
module ltw_filter (
   input wire logic clk, // System clock
   input wire logic reset, // Synchronous reset, high
   input wire logic level_in, // Raw function value
   input wire logic bypass, // Pass raw value straight through
   input wire logic [ltw_pkg::FILT_W-1:0] duration, // Cycles to stay true
   output logic level_out // Filtered function value
);
   logic [ltw_pkg::FILT_W-1:0] count_q;
   logic [ltw_pkg::FILT_W-1:0] count_d;
   logic reached;

   assign reached = (count_q >= duration);
   assign count_d = !level_in ? '0 : (reached ? count_q : count_q + 1'b1);
   assign level_out = bypass ? level_in : (level_in && reached); // see R12

   always_ff @(posedge clk) begin
      if (reset) begin
         count_q <= '0;
      end else begin
         count_q <= count_d; // see R25
      end
   end

   filter_short_a: assert property (@(posedge clk) disable iff (reset) // see R12
      (!bypass && $rose(level_in) && duration > 16'h0001) |-> !level_out)
      else $error("filter passed a pulse too early");
   filter_bypass_a: assert property (@(posedge clk) disable iff (reset) // see R15
      bypass |-> (level_out == level_in))
      else $error("filter bypass did not pass input");
endmodule : ltw_filter

// *** ltw_timebase_model.sv ***
// Time-base model: runs one sweep per accepted trigger and pulses sweep_done at its end
`timescale 1ns/10ps
module ltw_timebase_model #(
   parameter int SWEEP_CYC = 30 // Sweep length in cycles; small values give a prompt partner
) (
   input wire logic clk, // System clock
   input wire logic reset, // Synchronous reset, high
   input wire logic trigger_in, // Trigger from the recognizer
   output logic sweep_done // One-cycle pulse at sweep end
);
   int cnt_q;
   // A trigger arriving mid-sweep is ignored, as a real time base would do
   always_ff @(posedge clk) begin
      if (reset) begin
         cnt_q <= 0;
         sweep_done <= 1'b0;
      end else begin
         sweep_done <= (cnt_q == 1);
         if (cnt_q != 0) begin
            cnt_q <= cnt_q - 1;
         end else if (trigger_in) begin
            cnt_q <= SWEEP_CYC;
         end
      end
   end
endmodule : ltw_timebase_model

// *** ltw_recognizer_tb.sv ***
// Self-checking testbench for the logic-trigger word recognizer
`timescale 1ns/10ps
module ltw_recognizer_tb;
   typedef struct packed {
      logic [31:0] due;
      logic val;
   } ltw_note_s;
   localparam int LIMIT = 5000;
   logic clk = 1'b0, reset = 1'b1, reset_in = 1'b0, ext_in = 1'b0, ext_rise = 1'b1;
   logic q_req = 1'b0, fb_dis = 1'b0, gate = 1'b0, mon_req = 1'b0, alt_sel = 1'b1;
   logic [3:0] cmp = 4'h0, gnd = 4'h0, disp = 4'hF, fam = 4'h0;
   logic [15:0] filt = 16'h0000;
   ltw_pkg::ltw_prog_s prog = '0;
   ltw_pkg::ltw_mode_e mode = ltw_pkg::LTW_MODE_A;
   ltw_pkg::ltw_func_s fa = '0, fb = '0;
   logic trig, trace, mon_on, qual, rej, armed, sweep_done, mreq_p, ext_p, q_p, rst_p = 1'b1;
   logic [1:0] dch;
   logic [3:0] amp, ttl, disp_p;
   logic [31:0] rng = 32'h0000BDA1, cyc = 32'h0, hi_cnt = 32'h0, h;
   ltw_note_s q[$];
   int bad_count = 0, n_checks = 0;

   ltw_recognizer i_ltw_recognizer (.clk(clk), .reset(reset), .comparator_in(cmp),
      .channel_ground(gnd), .display_enable(disp), .logic_family_select(fam), .prog(prog),
      .mode(mode), .external_clock_qualify_req(q_req), .ext_clock_rising(ext_rise),
      .ext_clock_in(ext_in), .reset_in(reset_in), .filter_cycles(filt),
      .filter_b_disable(fb_dis), .gate_mode(gate), .monitor_req(mon_req),
      .alternate_chopped_select(alt_sel), .sweep_done(sweep_done), .trigger_out(trig),
      .trigger_monitor_trace(trace), .trigger_monitor_on(mon_on),
      .external_clock_qualify(qual), .prog_rejected(rej), .armed(armed),
      .display_channel(dch), .amp_in(amp), .ttl_range(ttl));
   ltw_timebase_model i_ltw_timebase_model (.clk(clk), .reset(reset), .trigger_in(trig),
      .sweep_done(sweep_done));

   initial begin
      forever #5 clk = ~clk;
   end

   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic finish_test;
      if (bad_count == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : finish_test

   // Snapshot of what the registers saw at this edge
   always @(posedge clk) begin
      cyc <= cyc + 1;
      mreq_p <= mon_req;
      disp_p <= disp;
      rst_p <= reset;
      ext_p <= ext_in;
      q_p <= qual;
      if (cyc >= LIMIT) begin
         bad_count++;
         finish_test();
      end
   end

   always @(negedge clk) begin
      ltw_note_s n;
      if (trig === 1'b1) hi_cnt++;
      if (rst_p === 1'b0) begin
         while (q.size() > 0 && q[0].due == cyc) begin
            n = q.pop_front();
            chk("trigger_out", 8'(trig), 8'(n.val));
         end
         chk("monitor_on", 8'(mon_on), 8'(mreq_p | (disp_p == 4'h0)));
         if (q_p === qual) chk("monitor_trace", 8'(trace), 8'(qual ? ext_p : trig));
      end
      chk("amp_in", 8'(amp), 8'(cmp & ~gnd));
      chk("ttl_range", 8'(ttl), 8'(fam));
   end

   function automatic logic ev(input ltw_pkg::ltw_func_s f, input logic [3:0] c, p);
      logic r, t, any;
      r = 1'b0;
      for (int k = 0; k < 2; k++) begin
         t = 1'b1;
         any = 1'b0;
         for (int j = 0; j < 4; j++) begin
            any |= f.col[k].term[j] != ltw_pkg::LTW_DONT_CARE;
            case (f.col[k].term[j])
               ltw_pkg::LTW_HIGH: t &= c[j];
               ltw_pkg::LTW_LOW: t &= ~c[j];
               ltw_pkg::LTW_RISE: t &= c[j] & ~p[j];
               ltw_pkg::LTW_FALL: t &= p[j] & ~c[j];
               default: t &= 1'b1;
            endcase
         end
         r |= t & any;
      end
      return r;
   endfunction : ev

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   task automatic drive(input logic [3:0] c, input int n);
      cmp = c;
      tick(n);
   endtask : drive

   task automatic wr(input logic b, c, input logic [1:0] ch, input ltw_pkg::ltw_term_e t,
                     input logic upd, cl);
      prog = '{write: 1'b1, clear: cl, sel_b: b, col: c, chan: ch, term: t};
      if (upd && cl && b) fb = '0;
      else if (upd && cl) fa = '0;
      else if (upd && b) fb.col[c].term[ch] = t;
      else if (upd) fa.col[c].term[ch] = t;
      tick(1);
      prog.write = 1'b0;
      tick(1);
   endtask : wr

   // Random words; the first cycles after a mode change are not judged
   task automatic run(input int n);
      logic [3:0] e, p;
      p = 4'h0;
      for (int i = 0; i < n; i++) begin
         rng ^= rng << 13;
         rng ^= rng >> 17;
         rng ^= rng << 5;
         cmp = rng[3:0];
         gnd = rng[7:4] & rng[11:8] & rng[15:12];
         disp = rng[19:16];
         mon_req = rng[20];
         fam = rng[24:21];
         e = cmp & ~gnd;
         if (i >= 3) q.push_back('{cyc + 2, ev(mode == ltw_pkg::LTW_MODE_B ? fb : fa, e, p)});
         p = e;
         tick(1);
      end
      gnd = 4'h0;
      // Let the last note be judged before the caller changes mode
      tick(1);
   endtask : run

   task automatic xclk(input int n);
      repeat (n) begin
         ext_in = 1'b1;
         tick(3);
         ext_in = 1'b0;
         tick(3);
      end
   endtask : xclk

   task automatic seqchk(input logic alt, input int n);
      logic sd;
      logic [1:0] ch;
      int last;
      alt_sel = alt;
      tick(3);
      last = -1;
      for (int i = 0; i < n; i++) begin
         sd = sweep_done;
         ch = dch;
         tick(1);
         if (alt) begin
            chk("alt_channel", 8'(dch), 8'(sd ? {~ch[1], 1'b0} : ch));
         end else if (dch !== ch) begin
            chk("chop_channel", 8'(dch), 8'({~ch[1], 1'b0}));
            if (last >= 0) chk("chop_period", 8'(i - last), 8'(ltw_pkg::CHOP_CYC));
            last = i;
         end
      end
      if (!alt) chk("chop_seen", 8'(last >= 0), 8'h01);
   endtask : seqchk

   initial begin
      tick(16);
      chk("reset_monitor_on", 8'(mon_on), 8'h01);
      chk("reset_channel", 8'(dch), 8'h00);
      chk("reset_trigger", 8'({trig, armed, qual, rej}), 8'h00);
      reset = 1'b0;
      wr(0, 0, 0, ltw_pkg::LTW_HIGH, 1, 0);
      wr(0, 0, 1, ltw_pkg::LTW_LOW, 1, 0);
      wr(0, 1, 3, ltw_pkg::LTW_HIGH, 1, 0);
      run(60);
      wr(1, 0, 2, ltw_pkg::LTW_FALL, 1, 0);
      wr(1, 1, 0, ltw_pkg::LTW_RISE, 1, 0);
      wr(1, 1, 1, ltw_pkg::LTW_HIGH, 1, 0);
      mode = ltw_pkg::LTW_MODE_B;
      run(60);
      mode = ltw_pkg::LTW_MODE_A;
      run(40);
      wr(0, 0, 0, ltw_pkg::LTW_DONT_CARE, 1, 1);
      run(30);
      mode = ltw_pkg::LTW_MODE_B;
      run(30);
      // Filter of five cycles: a three-cycle word is swallowed, a long one passes late
      mode = ltw_pkg::LTW_MODE_A;
      wr(0, 0, 0, ltw_pkg::LTW_HIGH, 1, 0);
      filt = 16'h0005;
      for (int i = 0; i < 22; i++) begin
         cmp = {3'h0, (i >= 6 && i < 9) || i >= 14};
         q.push_back('{cyc + 2, i >= 19});
         tick(1);
      end
      tick(1);
      mode = ltw_pkg::LTW_MODE_B;
      run(40);
      filt = 16'h0000;
      // Both functions false before nesting starts, so no stale trigger rises there
      cmp = 4'h4;
      // Nested: A is channel 0 high, B is channel 2 low
      wr(1, 0, 0, ltw_pkg::LTW_DONT_CARE, 1, 1);
      wr(1, 0, 2, ltw_pkg::LTW_LOW, 1, 0);
      mode = ltw_pkg::LTW_MODE_A_THEN_B;
      h = hi_cnt;
      drive(4'h4, 4);
      drive(4'h0, 4);
      chk("unarmed_fire", 8'(hi_cnt - h), 8'h00);
      drive(4'h5, 2);
      drive(4'h4, 3);
      chk("armed", 8'(armed), 8'h01);
      drive(4'h0, 6);
      chk("nested_pulse", 8'(hi_cnt - h), 8'h01);
      chk("disarmed", 8'(armed), 8'h00);
      drive(4'h4, 2);
      drive(4'h0, 4);
      chk("rearm_needed", 8'(hi_cnt - h), 8'h01);
      drive(4'h5, 2);
      drive(4'h4, 2);
      reset_in = 1'b1;
      tick(2);
      reset_in = 1'b0;
      chk("reset_in_disarm", 8'(armed), 8'h00);
      drive(4'h0, 4);
      chk("reset_in_inhibit", 8'(hi_cnt - h), 8'h01);
      gate = 1'b1;
      drive(4'h5, 2);
      drive(4'h4, 2);
      drive(4'h0, 6);
      chk("gate_long", 8'(hi_cnt - h > 4), 8'h01);
      gate = 1'b0;
      // Nested with a three-cycle filter on A only: short A does not arm, B fires at once
      filt = 16'h0003;
      fb_dis = 1'b1;
      drive(4'h5, 2);
      drive(4'h4, 2);
      chk("filter_a_short", 8'(armed), 8'h00);
      drive(4'h5, 6);
      drive(4'h4, 2);
      chk("filter_a_long", 8'(armed), 8'h01);
      h = hi_cnt;
      drive(4'h0, 3);
      chk("filter_b_off", 8'(hi_cnt - h), 8'h01);
      fb_dis = 1'b0;
      filt = 16'h0000;
      // Clock qualification against edge terms, both ways
      mode = ltw_pkg::LTW_MODE_A;
      wr(1, 1, 3, ltw_pkg::LTW_RISE, 1, 0);
      q_req = 1'b1;
      tick(3);
      chk("qualify_refused", 8'({qual, rej}), 8'h01);
      wr(1, 0, 0, ltw_pkg::LTW_DONT_CARE, 1, 1);
      tick(2);
      chk("qualify_on", 8'(qual), 8'h01);
      wr(0, 1, 1, ltw_pkg::LTW_RISE, 0, 0);
      chk("edge_refused", 8'(rej), 8'h01);
      h = hi_cnt;
      drive(4'h1, 1);
      xclk(8);
      drive(4'h0, 1);
      xclk(4);
      ext_rise = 1'b0;
      cmp = 4'h1;
      xclk(4);
      chk("qualified_count", 8'(hi_cnt - h), 8'h0C);
      q_req = 1'b0;
      tick(3);
      // Display sequencing over channels 0 and 2
      disp = 4'h5;
      seqchk(0, 350);
      seqchk(1, 300);
      finish_test();
   end
endmodule : ltw_recognizer_tb
